//--- hdl/settle_pkg.sv
// constants and register map shared by the settling sequencer files
package settle_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PERIOD_W = 16;
    localparam int CHAN_W = 4;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] PERIOD_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] MASK_OFS = 8'h0c;
    localparam logic [7:0] STATE_OFS = 8'h10;
    // control field positions
    localparam int CTRL_CHAN_LSB = 0;
    localparam int CTRL_CHOP_BIT = 4;
    // status and mask bit positions
    localparam int EV_READY_BIT = 0;
    localparam int EV_CHAN_BIT = 1;
    localparam int EV_STEP_BIT = 2;
    localparam int EV_W = 3;
    // state register bit positions
    localparam int ST_FLAG_BIT = 0;
    localparam int ST_VALID_BIT = 1;
    localparam int ST_LEFT_LSB = 2;
    localparam int ST_SETTLE_BIT = 4;
    // reset values
    localparam logic [CHAN_W-1:0] CHAN_RST = 4'h0;
    localparam logic CHOP_RST = 1'b1;
    localparam logic [PERIOD_W-1:0] PERIOD_RST = 16'h0100;
    localparam logic [EV_W-1:0] MASK_RST = 3'h0;
    // smallest conversion period the timer will run, in clock cycles
    localparam logic [PERIOD_W-1:0] PERIOD_MIN = 16'h0003;
    // conversions needed before a valid result
    localparam logic [1:0] CONV_CHAN_CHOP = 2'h2;
    localparam logic [1:0] CONV_CHAN_NOCHOP = 2'h1;
    localparam logic [1:0] CONV_STEP_MID_CHOP = 2'h3;
    localparam logic [1:0] CONV_STEP_MID_NOCHOP = 2'h2;
endpackage

//--- hdl/settle_timer_if.sv
// link between the sequencer and its conversion period timer
`timescale 1ns/1ps
interface settle_timer_if;
    logic restart;
    logic [settle_pkg::PERIOD_W-1:0] period;
    logic tick;
    logic pre_tick;
    logic at_start;
    modport ctrl (output restart, output period,
                  input tick, input pre_tick, input at_start);
    modport timer (input restart, input period,
                   output tick, output pre_tick, output at_start);
endinterface

//--- hdl/conv_timer.sv
// conversion period timer counting modulator clock cycles
`timescale 1ns/1ps
module conv_timer (
    input wire logic clk_in,
    input wire logic rst_in,
    settle_timer_if.timer tmr
);
    logic [settle_pkg::PERIOD_W-1:0] count_q;
    logic [settle_pkg::PERIOD_W-1:0] count_d;
    logic [settle_pkg::PERIOD_W-1:0] lim;

    // short periods are stretched so the pre-tick cycle always exists
    assign lim = (tmr.period < settle_pkg::PERIOD_MIN) ?
                 settle_pkg::PERIOD_MIN : tmr.period;
    assign tmr.tick = !tmr.restart && (count_q == lim - 16'h0001);
    assign tmr.pre_tick = !tmr.restart && (count_q == lim - 16'h0002);
    assign tmr.at_start = (count_q == 16'h0000);

    // next count: wrap at the period end or on a restart
    always_comb begin
        count_d = count_q + 16'h0001;
        if (tmr.restart || count_q >= lim - 16'h0001) begin
            count_d = 16'h0000;
        end
    end

    // count register
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            count_q <= 16'h0000;
        end else begin
            count_q <= count_d;
        end
    end
endmodule // conv_timer

//--- hdl/sigma_delta_settling_sequencer.sv
// settling sequencer: decides when a conversion result is valid
// What this block does
// - channel change resets filter and restarts the conversion timer
// - chopped channel change: flag high two conversions
// - input step: no reset, flag keeps pulsing
// - chopped step: valid after two or three
// - unchopped channel change: valid after one conversion
`timescale 1ns/1ps
module sigma_delta_settling_sequencer (
    input wire logic CLOCK_IN,
    input wire logic SYS_RST_IN,
    input wire logic [settle_pkg::ADDR_W-1:0] ADDR_IN,
    input wire logic [settle_pkg::DATA_W-1:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [settle_pkg::DATA_W-1:0] RDATA_OUT,
    input wire logic STEP_IN,
    output logic FILTER_RST_OUT,
    output logic CONV_END_OUT,
    output logic [settle_pkg::CHAN_W-1:0] CHANNEL_OUT,
    output logic CHOP_EN_OUT,
    output logic RESULT_VALID_OUT,
    output logic CONVERSION_READY_FLAG_OUT,
    output logic IRQ_OUT
);
    settle_timer_if tmr_if ();

    logic [settle_pkg::CHAN_W-1:0] chan_q, chan_d;
    logic chop_q, chop_d;
    logic [settle_pkg::PERIOD_W-1:0] period_q, period_d;
    logic [settle_pkg::EV_W-1:0] status_q, status_d, mask_q, mask_d;
    logic [settle_pkg::DATA_W-1:0] rdata_q, rdata_d;
    logic [1:0] left_q, left_d;
    logic flag_q, flag_d, valid_q, valid_d, settling_q, settling_d;
    logic filter_rst_q, filter_rst_d, conv_end_q, conv_end_d;
    logic step_m_q, step_s_q, step_p_q;
    logic wr_ctrl, chan_change, step_edge, tick_valid;
    logic [settle_pkg::EV_W-1:0] events, clr_mask;

    // register file decode used by the write and read paths
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    conv_timer u_timer (
        .clk_in(CLOCK_IN),
        .rst_in(SYS_RST_IN),
        .tmr(tmr_if.timer)
    );

    // step input comes from a pin: two stages, then edge detect
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            step_m_q <= 1'b0;
            step_s_q <= 1'b0;
            step_p_q <= 1'b0;
        end else begin
            step_m_q <= STEP_IN;
            step_s_q <= step_m_q;
            step_p_q <= step_s_q;
        end
    end
    assign step_edge = step_s_q && !step_p_q;

    // a channel change is a control write carrying a different channel
    assign wr_ctrl = WR_IN && hit(ADDR_IN, settle_pkg::CTRL_OFS);
    assign chan_change = wr_ctrl && (WDATA_IN[settle_pkg::CTRL_CHAN_LSB +:
                         settle_pkg::CHAN_W] != chan_q);
    assign tmr_if.restart = chan_change;
    assign tmr_if.period = period_q;
    assign tick_valid = tmr_if.tick && (left_q <= 2'h1);

    // settling sequencer next state
    always_comb begin
        left_d = left_q;
        flag_d = flag_q;
        valid_d = valid_q;
        settling_d = settling_q;
        filter_rst_d = 1'b0;
        conv_end_d = tmr_if.tick;
        if (tmr_if.pre_tick) begin
            flag_d = 1'b1;
        end
        if (tmr_if.tick) begin
            valid_d = left_q <= 2'h1;
            if (left_q != 2'h0) begin
                left_d = left_q - 2'h1;
            end
            if (tick_valid) begin
                flag_d = 1'b0;
                settling_d = 1'b0;
            end else begin
                flag_d = settling_q;
            end
        end
        if (chan_change) begin
            filter_rst_d = 1'b1;
            flag_d = 1'b1;
            valid_d = 1'b0;
            settling_d = 1'b1;
            conv_end_d = 1'b0;
            left_d = chop_d ? settle_pkg::CONV_CHAN_CHOP :
                     settle_pkg::CONV_CHAN_NOCHOP;
        end else if (step_edge) begin
            valid_d = 1'b0;
            if (tmr_if.at_start) begin
                left_d = chop_q ? settle_pkg::CONV_CHAN_CHOP :
                         settle_pkg::CONV_CHAN_NOCHOP;
            end else begin
                left_d = chop_q ? settle_pkg::CONV_STEP_MID_CHOP :
                         settle_pkg::CONV_STEP_MID_NOCHOP;
            end
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            left_q <= settle_pkg::CONV_CHAN_CHOP;
            flag_q <= 1'b1;
            valid_q <= 1'b0;
            settling_q <= 1'b1;
            filter_rst_q <= 1'b0;
            conv_end_q <= 1'b0;
        end else begin
            left_q <= left_d;
            flag_q <= flag_d;
            valid_q <= valid_d;
            settling_q <= settling_d;
            filter_rst_q <= filter_rst_d;
            conv_end_q <= conv_end_d;
        end
    end

    // events, write-one-to-clear with set winning over clear
    always_comb begin
        events = '0;
        events[settle_pkg::EV_READY_BIT] = tick_valid && !chan_change;
        events[settle_pkg::EV_CHAN_BIT] = chan_change;
        events[settle_pkg::EV_STEP_BIT] = step_edge;
        clr_mask = '0;
        if (WR_IN && hit(ADDR_IN, settle_pkg::STATUS_OFS)) begin
            clr_mask = WDATA_IN[settle_pkg::EV_W-1:0];
        end
        status_d = (status_q & ~clr_mask) | events;
    end

    // register writes and registered read data
    always_comb begin
        chan_d = chan_q;
        chop_d = chop_q;
        period_d = period_q;
        mask_d = mask_q;
        rdata_d = '0;
        if (wr_ctrl) begin
            chan_d = WDATA_IN[settle_pkg::CTRL_CHAN_LSB +:
                              settle_pkg::CHAN_W];
            chop_d = WDATA_IN[settle_pkg::CTRL_CHOP_BIT];
        end
        if (WR_IN && hit(ADDR_IN, settle_pkg::PERIOD_OFS)) begin
            period_d = WDATA_IN[settle_pkg::PERIOD_W-1:0];
        end
        if (WR_IN && hit(ADDR_IN, settle_pkg::MASK_OFS)) begin
            mask_d = WDATA_IN[settle_pkg::EV_W-1:0];
        end
        if (RD_IN) begin
            if (hit(ADDR_IN, settle_pkg::CTRL_OFS)) begin
                rdata_d[settle_pkg::CTRL_CHAN_LSB +:
                        settle_pkg::CHAN_W] = chan_q;
                rdata_d[settle_pkg::CTRL_CHOP_BIT] = chop_q;
            end else if (hit(ADDR_IN, settle_pkg::PERIOD_OFS)) begin
                rdata_d[settle_pkg::PERIOD_W-1:0] = period_q;
            end else if (hit(ADDR_IN, settle_pkg::STATUS_OFS)) begin
                rdata_d[settle_pkg::EV_W-1:0] = status_q;
            end else if (hit(ADDR_IN, settle_pkg::MASK_OFS)) begin
                rdata_d[settle_pkg::EV_W-1:0] = mask_q;
            end else if (hit(ADDR_IN, settle_pkg::STATE_OFS)) begin
                rdata_d[settle_pkg::ST_FLAG_BIT] = flag_q;
                rdata_d[settle_pkg::ST_VALID_BIT] = valid_q;
                rdata_d[settle_pkg::ST_LEFT_LSB +: 2] = left_q;
                rdata_d[settle_pkg::ST_SETTLE_BIT] = settling_q;
            end
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            chan_q <= settle_pkg::CHAN_RST;
            chop_q <= settle_pkg::CHOP_RST;
            period_q <= settle_pkg::PERIOD_RST;
            mask_q <= settle_pkg::MASK_RST;
            status_q <= '0;
            rdata_q <= '0;
        end else begin
            chan_q <= chan_d;
            chop_q <= chop_d;
            period_q <= period_d;
            mask_q <= mask_d;
            status_q <= status_d;
            rdata_q <= rdata_d;
        end
    end

    // outputs
    assign RDATA_OUT = rdata_q;
    assign FILTER_RST_OUT = filter_rst_q;
    assign CONV_END_OUT = conv_end_q;
    assign CHANNEL_OUT = chan_q;
    assign CHOP_EN_OUT = chop_q;
    assign RESULT_VALID_OUT = valid_q;
    assign CONVERSION_READY_FLAG_OUT = flag_q;
    assign IRQ_OUT = |(status_q & mask_q);

    // helper: conversions completed since the last channel change or step
    logic [1:0] since_q;
    logic [1:0] kind_q; // 0 chan, 1 aligned step, 2 mid step
    logic hchop_q;
    always_ff @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            since_q <= 2'h3;
            kind_q <= 2'h0;
            hchop_q <= 1'b0;
        end else if (chan_change) begin
            since_q <= 2'h0;
            kind_q <= 2'h0;
            hchop_q <= chop_d;
        end else if (step_edge) begin
            since_q <= 2'h0;
            kind_q <= tmr_if.at_start ? 2'h1 : 2'h2;
            hchop_q <= chop_q;
        end else if (tmr_if.tick && since_q != 2'h3) begin
            since_q <= since_q + 2'h1;
        end
    end

    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (SYS_RST_IN);

    sequence s_chan_reset;
        filter_rst_q && flag_q && !valid_q;
    endsequence
    sequence s_valid_out;
        !flag_q && valid_q;
    endsequence
    logic quiet;
    assign quiet = !chan_change && !step_edge;

    a_chan_resets: assert property (chan_change |=> s_chan_reset)
        else $error("channel change did not reset filter");
    a_chop_chan_hold: assert property (tmr_if.tick && quiet && since_q == 2'h0
        && kind_q == 2'h0 && hchop_q |=> flag_q ##1 flag_q)
        else $error("flag fell after one chopped conversion");
    a_chop_chan_done: assert property (tmr_if.tick && quiet && since_q == 2'h1
        && kind_q == 2'h0 && hchop_q |=> s_valid_out)
        else $error("no valid result two conversions after change");
    a_step_no_reset: assert property (step_edge && !chan_change
        |=> !filter_rst_q ##1 !filter_rst_q)
        else $error("input step reset the filter");
    a_step_pulses: assert property (tmr_if.tick && quiet && kind_q != 2'h0
        && since_q != 2'h3 |=> !flag_q)
        else $error("flag did not pulse during step settling");
    a_step_mid_three: assert property (tmr_if.tick && quiet && hchop_q
        && kind_q == 2'h2 && since_q == 2'h1 |=> !valid_q)
        else $error("mid step valid before third conversion");
    a_step_mid_valid: assert property (tmr_if.tick && quiet && hchop_q
        && kind_q == 2'h2 && since_q == 2'h2 |=> valid_q)
        else $error("mid step not valid at third conversion");
    a_step_aligned: assert property (tmr_if.tick && quiet && hchop_q
        && kind_q == 2'h1 && since_q == 2'h1 |=> valid_q)
        else $error("aligned step not valid at second conversion");
    a_nochop_one: assert property (tmr_if.tick && quiet && !hchop_q
        && kind_q == 2'h0 && since_q == 2'h0 |=> s_valid_out)
        else $error("unchopped change not valid after one conversion");
    a_flag_pre_high: assert property (tmr_if.pre_tick |=> flag_q)
        else $error("flag not high before conversion end");

    // timer restart, sticky events and levels held between conversions
    a_restart_timer: assert property (chan_change
        |=> tmr_if.at_start)
        else $error("channel change did not restart the timer");
    a_same_chan: assert property (wr_ctrl && !chan_change
        |=> !filter_rst_q)
        else $error("same channel write reset the filter");
    a_chan_sticky: assert property (chan_change
        |=> status_q[settle_pkg::EV_CHAN_BIT])
        else $error("channel change event not recorded");
    a_step_drops_valid: assert property (step_edge && !chan_change
        |=> !valid_q)
        else $error("input step left the result valid");
    a_step_sticky: assert property (step_edge
        |=> status_q[settle_pkg::EV_STEP_BIT])
        else $error("input step event not recorded");
    a_step_mid_nochop: assert property (tmr_if.tick && quiet
        && !hchop_q && kind_q == 2'h2 && since_q == 2'h1 |=> s_valid_out)
        else $error("unchopped mid step not valid at second conversion");
    a_step_al_nochop: assert property (tmr_if.tick && quiet
        && !hchop_q && kind_q == 2'h1 && since_q == 2'h0 |=> s_valid_out)
        else $error("unchopped aligned step not valid at first conversion");
    a_valid_flag_low: assert property (tick_valid && quiet
        |=> s_valid_out)
        else $error("flag not low on a valid result");
    a_ready_sticky: assert property (tick_valid && !chan_change
        |=> status_q[settle_pkg::EV_READY_BIT])
        else $error("valid result event not recorded");
    a_valid_steady: assert property (!tmr_if.tick && quiet
        |=> $stable(valid_q))
        else $error("result valid changed between conversions");
    a_settle_flag_hi: assert property (settling_q && !tick_valid
        |=> flag_q)
        else $error("flag fell while the channel was settling");
endmodule // sigma_delta_settling_sequencer

//--- tb/host_model.sv
// host side model that takes ready results and tracks calibration duty
`timescale 1ns/1ps
module host_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic flag_in,
    input wire logic valid_in,
    input wire logic cfg_in,
    output logic [7:0] taken_out,
    output logic cal_due_out
);
    logic flag_q;
    logic [7:0] taken_q;
    logic [7:0] taken_d;
    logic cal_q;
    logic cal_d;
    // a word is taken when the flag falls on a valid result
    always_comb begin
        taken_d = taken_q;
        cal_d = cal_q | cfg_in;
        if (flag_q && !flag_in && valid_in) begin
            taken_d = taken_q + 8'h01;
        end
    end
    // registers of the host view
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            flag_q <= 1'b1;
            taken_q <= 8'h00;
            cal_q <= 1'b0;
        end else begin
            flag_q <= flag_in;
            taken_q <= taken_d;
            cal_q <= cal_d;
        end
    end
    assign taken_out = taken_q;
    assign cal_due_out = cal_q;
endmodule // host_model

//--- tb/sigma_delta_settling_sequencer_test.sv
// register level tests of the settling sequencer
`timescale 1ns/1ps
module sigma_delta_settling_sequencer_test;
    logic clk, rst, wr, rd, step, cfg;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    logic frst, cend, chop, valid, flag, irq;
    logic [3:0] chan;
    logic [7:0] taken, t0;
    logic cal_due;
    int mismatches = 0;
    int checks = 0;
    int c, l, r;

    sigma_delta_settling_sequencer sigma_delta_settling_sequencer_inst (
        .CLOCK_IN(clk), .SYS_RST_IN(rst), .ADDR_IN(addr),
        .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
        .STEP_IN(step), .FILTER_RST_OUT(frst), .CONV_END_OUT(cend),
        .CHANNEL_OUT(chan), .CHOP_EN_OUT(chop), .RESULT_VALID_OUT(valid),
        .CONVERSION_READY_FLAG_OUT(flag), .IRQ_OUT(irq));
    host_model host_model_inst (
        .clk_in(clk), .rst_in(rst), .flag_in(flag), .valid_in(valid),
        .cfg_in(cfg), .taken_out(taken), .cal_due_out(cal_due));

    // clock of 4 ns
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic wrap_up();
        if (mismatches == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t bit %b expected %b", $time, got, exp);
        end
    endtask

    // one write cycle, then settle past the taking edge
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        cfg <= (a == settle_pkg::PERIOD_OFS);
        @(posedge clk);
        wr <= 1'b0;
        cfg <= 1'b0;
        #1;
    endtask

    // one read cycle, data sampled in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check_word(rdata, exp);
    endtask

    // count conversions, flag lows and resets until a valid result
    task automatic settle(input logic hold, output int cv, output int lw,
                          output int rs);
        cv = 0;
        lw = 0;
        rs = 0;
        for (int i = 0; i < 1000; i++) begin
            @(posedge clk);
            #1;
            if (frst === 1'b1) rs++;
            if (cend === 1'b1) cv++;
            if (cend === 1'b1 && flag === 1'b0) lw++;
            if (valid === 1'b1) break;
            if (hold && flag !== 1'b1) lw++;
        end
        if (valid !== 1'b1) begin
            mismatches++;
            $display("ERROR %0t no valid result", $time);
        end
    endtask

    // input step raised gap edges after a conversion end
    task automatic step_mid(input int gap, output int cv, output int lw,
                            output int rs);
        int i;
        i = 0;
        while (cend !== 1'b1 && i < 1000) begin
            @(posedge clk);
            #1;
            i++;
        end
        if (i >= 1000) begin
            mismatches++;
            $display("ERROR %0t no conversion end", $time);
        end
        repeat (gap) @(posedge clk);
        step <= 1'b1;
        repeat (8) @(posedge clk);
        step <= 1'b0;
        settle(1'b0, cv, lw, rs);
    endtask

    // guard against a hang
    initial begin
        #100000;
        mismatches++;
        wrap_up();
    end

    // main sequence
    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        step = 1'b0;
        cfg = 1'b0;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd_chk(settle_pkg::CTRL_OFS, 32'h0000_0010);
        rd_chk(settle_pkg::PERIOD_OFS, 32'h0000_0100);
        rd_chk(settle_pkg::STATE_OFS, 32'h0000_0019);
        rd_chk(8'h14, 32'h0000_0000);
        wr_reg(settle_pkg::PERIOD_OFS, 32'h0000_0010);
        check_bit(cal_due, 1'b1);
        // chopped channel change
        t0 = taken;
        wr_reg(settle_pkg::CTRL_OFS, 32'h0000_0013);
        check_bit(frst, 1'b1);
        check_bit(flag, 1'b1);
        settle(1'b1, c, l, r);
        check_word(c, 2);
        check_word(l, 1);
        check_word(r, 0);
        check_word({28'h0, chan}, 32'h0000_0003);
        @(posedge clk);
        #1;
        check_word({24'h0, taken - t0}, 32'h0000_0001);
        // same channel with chop off is no change
        wr_reg(settle_pkg::CTRL_OFS, 32'h0000_0003);
        check_bit(frst, 1'b0);
        check_bit(chop, 1'b0);
        // unchopped channel change
        wr_reg(settle_pkg::CTRL_OFS, 32'h0000_0005);
        check_bit(frst, 1'b1);
        settle(1'b1, c, l, r);
        check_word(c, 1);
        // unchopped and chopped steps in mid conversion
        step_mid(2, c, l, r);
        check_word(c, 2);
        check_word(l, 2);
        check_word(r, 0);
        wr_reg(settle_pkg::CTRL_OFS, 32'h0000_0015);
        step_mid(2, c, l, r);
        check_word(c, 3);
        check_word(l, 3);
        check_word(r, 0);
        // chopped aligned step: with period 16 the pin rises 14 edges
        // after a conversion end, so the synced edge meets count zero
        step_mid(14, c, l, r);
        check_word(c, 2);
        check_word(l, 2);
        check_word(r, 0);
        // sticky events, mask and clear
        rd_chk(settle_pkg::STATUS_OFS, 32'h0000_0007);
        check_bit(irq, 1'b0);
        wr_reg(settle_pkg::MASK_OFS, 32'h0000_0004);
        check_bit(irq, 1'b1);
        wr_reg(settle_pkg::STATUS_OFS, 32'h0000_0004);
        check_bit(irq, 1'b0);
        rd_chk(settle_pkg::STATUS_OFS, 32'h0000_0003);
        rd_chk(settle_pkg::MASK_OFS, 32'h0000_0004);
        wrap_up();
    end
endmodule // sigma_delta_settling_sequencer_test
